/* bmu_defs.vh */
// Constants for the byte multiplier unit.
// Assumes inclusion by bare name from the same folder.
`ifndef BMU_DEFS_VH
`define BMU_DEFS_VH
`define BMU_OPER_W      8
`define BMU_PROD_W      16
`define BMU_HI_MSB      15
`define BMU_HI_LSB      8
`define BMU_LO_MSB      7
`define BMU_LO_LSB      0
`define BMU_BYTE_RST    8'h00
`define BMU_FLAG_W      5
`define BMU_FLAG_RST    5'h00
`endif

/* bmu_mul_core.v */
// Unsigned combinational byte multiplier core.
// Assumes operands are stable for the cycle in which the product is captured.
`timescale 1ns/1ps
`default_nettype none
module bmu_mul_core #(
  parameter OPER_W = 8
) (
  // Operands
  input  wire [OPER_W-1:0]   op_a,
  input  wire [OPER_W-1:0]   op_b,
  // Product
  output wire [2*OPER_W-1:0] prod
);
  // Full unsigned product
  assign prod = op_a * op_b;
endmodule
`default_nettype wire

/* bmu_byte_multiplier_unit.v */
// Byte multiplier unit: working register times file register into product pair.
// Assumes the core execution datapath supplies operands, strobes and flags on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "bmu_defs.vh"
// Functional notes
// - Both 8-bit operands are unsigned; the full unsigned product is computed.
// - The 16-bit product goes high byte to high register, low byte to low.
// - A multiply leaves every status flag exactly as it was.
// - The product is ready by the next instruction, one cycle after the strobe.
// - One operand is the working register, the other the addressed file register.
module bmu_byte_multiplier_unit #(
  parameter OPER_W = 8
) (
  // Clock and reset
  input  wire                   ref_clk,
  input  wire                   nrst,
  // Instruction strobe and operands
  input  wire                   multiply_working_by_file,
  input  wire [OPER_W-1:0]      working_register,
  input  wire [OPER_W-1:0]      file_register,
  // Software writes to the product pair
  input  wire                   wr_high_en,
  input  wire                   wr_low_en,
  input  wire [OPER_W-1:0]      wr_data,
  // Status flags
  input  wire                   flag_wr_en,
  input  wire [`BMU_FLAG_W-1:0] flag_wr_data,
  output reg  [`BMU_FLAG_W-1:0] status_flags_q,
  // Product pair
  output reg  [OPER_W-1:0]      product_high_byte_q,
  output reg  [OPER_W-1:0]      product_low_byte_q
);

  // Byte source selects
  localparam [1:0] SRC_HOLD = 2'b00;
  localparam [1:0] SRC_MUL  = 2'b01;
  localparam [1:0] SRC_SOFT = 2'b10;
  localparam       PROD_W   = 2 * OPER_W;

  // Reset synchroniser stages
  reg                    rst_s1_q;
  reg                    rst_s2_q;
  wire                   rst_n;

  // Multiplier result
  wire [PROD_W-1:0]      prod;
  wire [OPER_W-1:0]      prod_high;
  wire [OPER_W-1:0]      prod_low;

  // Byte selects
  reg  [1:0]             high_sel;
  reg  [1:0]             low_sel;

  // Next values
  reg  [OPER_W-1:0]      high_d;
  reg  [OPER_W-1:0]      low_d;
  reg  [`BMU_FLAG_W-1:0] flags_d;

  // Reset release synchroniser
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  assign rst_n = rst_s2_q;

  // Multiplier array
  bmu_mul_core #(
    .OPER_W (OPER_W)
  ) u_core (
    .op_a (working_register),
    .op_b (file_register),
    .prod (prod)
  );

  // Product split into bytes
  assign prod_high = prod[PROD_W-1:OPER_W];
  assign prod_low  = prod[OPER_W-1:0];

  // High byte source; multiply wins over software write
  always @*
  begin
    high_sel = SRC_HOLD;
    if (multiply_working_by_file)
    begin
      high_sel = SRC_MUL;
    end
    else if (wr_high_en)
    begin
      high_sel = SRC_SOFT;
    end
  end

  // Low byte source; multiply wins over software write
  always @*
  begin
    low_sel = SRC_HOLD;
    if (multiply_working_by_file)
    begin
      low_sel = SRC_MUL;
    end
    else if (wr_low_en)
    begin
      low_sel = SRC_SOFT;
    end
  end

  // High byte next value
  always @*
  begin
    case (high_sel)
      SRC_MUL:
      begin
        high_d = prod_high;
      end
      SRC_SOFT:
      begin
        high_d = wr_data;
      end
      SRC_HOLD:
      begin
        high_d = product_high_byte_q;
      end
      default:
      begin
        high_d = product_high_byte_q;
      end
    endcase
  end

  // Low byte next value
  always @*
  begin
    case (low_sel)
      SRC_MUL:
      begin
        low_d = prod_low;
      end
      SRC_SOFT:
      begin
        low_d = wr_data;
      end
      SRC_HOLD:
      begin
        low_d = product_low_byte_q;
      end
      default:
      begin
        low_d = product_low_byte_q;
      end
    endcase
  end

  // Flags follow only their own writes
  always @*
  begin
    flags_d = status_flags_q;
    if (flag_wr_en)
    begin
      flags_d = flag_wr_data;
    end
  end

  // High byte capture in one cycle
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      product_high_byte_q <= `BMU_BYTE_RST;
    end
    else
    begin
      product_high_byte_q <= high_d;
    end
  end

  // Low byte capture in one cycle
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      product_low_byte_q <= `BMU_BYTE_RST;
    end
    else
    begin
      product_low_byte_q <= low_d;
    end
  end

  // Status flags register
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_flags_q <= `BMU_FLAG_RST;
    end
    else
    begin
      status_flags_q <= flags_d;
    end
  end

endmodule
`default_nettype wire

/* bmu_monitor.sv */
// Checker on the unit ports, bound to its top module.
// Assumes the top module port names are unchanged.
`timescale 1ns/1ps
`default_nettype none
module bmu_chk (input wire logic ref_clk, nrst, multiply_working_by_file, wr_high_en, wr_low_en, flag_wr_en,
  input wire logic [7:0] working_register, file_register, product_high_byte_q, product_low_byte_q, wr_data,
  input wire logic [4:0] status_flags_q, flag_wr_data);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire logic m = multiply_working_by_file;
  wire logic [15:0] p = working_register * file_register, q = {product_high_byte_q, product_low_byte_q};
  prod_pair_a: assert property (m |=> q == $past(p)) else $error("product wrong");
  pair_hold_a: assert property (!m && !wr_high_en && !wr_low_en |=> $stable(q)) else $error("product moved");
  flag_keep_a: assert property (!flag_wr_en |=> $stable(status_flags_q)) else $error("flags moved");
  flag_mul_a: assert property (m && !flag_wr_en |=> $stable(status_flags_q)) else $error("multiply hit flags");
  high_write_a: assert property (wr_high_en && !m |=> product_high_byte_q == $past(wr_data)) else $error("high write lost");
  low_write_a: assert property (wr_low_en && !m |=> product_low_byte_q == $past(wr_data)) else $error("low write lost");
  cover property (m && wr_high_en);
  cover property (m && p == 16'hFE01);
  cover property (wr_high_en && !m);
endmodule
bind bmu_byte_multiplier_unit bmu_chk chk (.*);
`default_nettype wire

/* bmu_core.sv */
// Core datapath model driving strobes and operands.
// Assumes the unit samples on rising ref_clk.
`timescale 1ns/1ps
`default_nettype none
module bmu_core (input wire logic ref_clk, input wire logic [7:0] hi,
  output logic [3:0] s = 4'h0, output logic [7:0] w = 8'h00, f = 8'h00);
  task automatic op(input logic [3:0] c, input logic [7:0] a, b);
    @(posedge ref_clk) {s, w, f} <= {c, a, b};
    @(posedge ref_clk) s <= 4'h0;
    #1;
  endtask
  task automatic smul(input logic [7:0] a, b);
    op(4'h8, a, b);
    op(4'h4, a, hi - (b[7] ? a : 8'h00) - (a[7] ? b : 8'h00));
  endtask
endmodule
`default_nettype wire

/* bmu_byte_multiplier_unit_bench.sv */
// Self-checking bench; the core model drives the unit.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
`default_nettype none
module bmu_byte_multiplier_unit_bench;
  logic ref_clk = 0, nrst = 0;
  logic [3:0] s;
  logic [4:0] fl;
  logic [7:0] w, f, hi, lo;
  int miscompares = 0, n_tests = 0, cyc = 0;
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cyc == 500) begin miscompares++; close_out; end
  bmu_core core (.ref_clk(ref_clk), .hi(hi), .s(s), .w(w), .f(f));
  bmu_byte_multiplier_unit uut (.ref_clk(ref_clk), .nrst(nrst), .multiply_working_by_file(s[3]), .wr_high_en(s[2]),
    .wr_low_en(s[1]), .flag_wr_en(s[0]), .working_register(w), .file_register(f), .wr_data(f),
    .flag_wr_data(w[4:0]), .status_flags_q(fl), .product_high_byte_q(hi), .product_low_byte_q(lo));
  task automatic chk(input logic [20:0] got, exp);
    n_tests++;
    if (got !== exp) miscompares++;
    if (got !== exp) $display("Error at %0t: %h vs %h", $time, got, exp);
  endtask
  task automatic close_out;
    $display("Compares %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic t_mul;
    core.op(4'h1, 8'h15, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      core.op(4'h8, 8'hFF >> i, 8'hFF << i);
      chk({fl, hi, lo}, {5'h15, 16'(8'hFF >> i) * 8'(8'hFF << i)});
    end
    core.op(4'h0, 8'h0A, 8'h00);
    chk({hi, lo}, 16'h1E08);
    $display("t_mul done");
  endtask
  task automatic t_soft;
    core.op(4'h4, 8'h00, 8'h5A);
    chk(hi, 8'h5A);
    core.op(4'hC, 8'h10, 8'h10);
    chk({hi, lo}, 16'h0100);
    core.smul(8'hFF, 8'h02);
    chk(hi, 8'hFF);
    $display("t_soft done");
  endtask
  task automatic t_reset;
    core.op(4'h2, 8'h00, 8'hA5);
    chk({hi, lo}, 16'hFFA5);
    @(posedge ref_clk) nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk({fl, hi, lo}, 21'h000000);
    @(posedge ref_clk) nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    core.op(4'h8, 8'h0F, 8'h11);
    chk({fl, hi, lo}, 21'h0000FF);
    $display("t_reset done");
  endtask
  initial
  begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_mul;
    t_soft;
    t_reset;
    close_out;
  end
endmodule
`default_nettype wire
